// ### tb/ssram_host_model.sv
`timescale 1ns/1ps
module ssram_host_model (
  // clock
  input  wire logic ref_clk_i,
  // resolved pin levels
  input  wire logic line0_i,
  input  wire logic line1_i,
  // host drive
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      line0_o,
  output logic      line1_o,
  output logic      line0_en_o,
  output logic      line1_en_o
);
  logic dual_mode = 1'b0;
  int   cut_bits  = 0;
  // serial clock idles low and stands still between frames
  initial begin
    cs_n_o     = 1'b1;
    sck_o      = 1'b0;
    line0_o    = 1'b0;
    line1_o    = 1'b0;
    line0_en_o = 1'b0;
    line1_en_o = 1'b0;
  end
  task automatic start;
    @(posedge ref_clk_i);
    cs_n_o <= 1'b0;
  endtask
  task automatic stop;
    @(posedge ref_clk_i);
    sck_o <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    cs_n_o     <= 1'b1;
    line0_en_o <= 1'b0;
    line1_en_o <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask
  // cut_bits stops a byte short to model an aborted transfer
  task automatic xb(input logic [7:0] o, input logic drv, output logic [7:0] i);
    logic [7:0] sh;
    int         n;
    sh = o;
    n  = (cut_bits != 0) ? cut_bits : (dual_mode ? 4 : 8);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk_i);
      sck_o      <= 1'b0;
      line0_en_o <= drv | ~dual_mode;
      line1_en_o <= drv & dual_mode;
      line0_o    <= dual_mode ? sh[6] : sh[7];
      line1_o    <= sh[7];
      sh = dual_mode ? {sh[5:0], 2'b00} : {sh[6:0], 1'b0};
      repeat (4) @(posedge ref_clk_i);
      sck_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      i = dual_mode ? {i[5:0], line1_i, line0_i} : {i[6:0], line1_i};
    end
  endtask
endmodule

// ### tb/ssram_spi_checker.sv
`timescale 1ns/1ps
module ssram_spi_checker
  import ssram_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // serial link pins
  input  wire logic       cs_n_i,
  input  wire logic       sck_i,
  input  wire logic       dual_line_zero_oe_n_o,
  input  wire logic       dual_line_one_o,
  input  wire logic       dual_line_one_oe_n_o,
  // status
  input  wire logic       dual_serial_operation_o,
  input  wire logic [7:0] access_pattern_config_o
);
  // cycles with select seen high, saturating
  logic [3:0] hi_cnt_ff;
  logic [3:0] nxt_hi_cnt;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  always_comb begin
    nxt_hi_cnt = 4'h0;
    if (cs_n_i) begin
      nxt_hi_cnt = (hi_cnt_ff == 4'hF) ? hi_cnt_ff : hi_cnt_ff + 4'h1;
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt_ff <= 4'h0;
    end else begin
      hi_cnt_ff <= nxt_hi_cnt;
    end
  end
  // pins cross a synchroniser, so outputs trail the pin edges
  sequence after_fall_s;
    !$past(sck_i, 2) && !$past(cs_n_i, 3);
  endsequence
  sequence in_frame_s;
    hi_cnt_ff < 4'h4;
  endsequence
  cfg_reset_a: assert property ($fell(rst_i) |-> access_pattern_config_o == SSRAM_CFG_RESET)
    else $error("config reset value wrong");
  cfg_reserved_a: assert property (access_pattern_config_o[5:0] == 6'h00)
    else $error("config reserved bits set");
  cfg_framed_a: assert property ($changed(access_pattern_config_o) |-> in_frame_s)
    else $error("config changed outside a frame");
  dual_framed_a: assert property ($changed(dual_serial_operation_o) |-> in_frame_s)
    else $error("dual mode changed outside a frame");
  idle_release_a: assert property (hi_cnt_ff > 4'h5 |-> dual_line_zero_oe_n_o && dual_line_one_oe_n_o)
    else $error("line driven while deselected");
  drive_start_a: assert property ($fell(dual_line_one_oe_n_o) |-> after_fall_s)
    else $error("output enabled off the falling edge");
  data_edge_a: assert property ($changed(dual_line_one_o) && !dual_line_one_oe_n_o |-> after_fall_s)
    else $error("output data moved off the falling edge");
  zero_dual_a: assert property (!dual_line_zero_oe_n_o |-> dual_serial_operation_o)
    else $error("line zero driven in single mode");
endmodule

bind ssram_spi_slave ssram_spi_checker u_chk (.ref_clk_i, .rst_i, .cs_n_i, .sck_i, .dual_line_zero_oe_n_o,
  .dual_line_one_o, .dual_line_one_oe_n_o, .dual_serial_operation_o, .access_pattern_config_o);

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import ssram_pkg::*;
  typedef struct {
    logic [1:0]  pat;
    logic [15:0] adr;
    int          nw;
    int          nr;
  } ssram_row_t;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       tog = 1'b0;
  logic       cs_n, sck, h0, h1, h0_en, h1_en, d0_o, d0_oe_n, d1_o, d1_oe_n, dual;
  logic [7:0] cfg_o;
  logic [7:0] x;
  wire        l0;
  wire        l1;
  int         n_fail = 0;
  int         checks = 0;
  int         drv_cnt = 0;
  int         base;
  logic [7:0] mem [int];
  ssram_row_t rows [5] = '{
    '{SSRAM_PAT_SEQ, 16'hFFFF, 3, 3},
    '{SSRAM_PAT_PAGE, 16'h001F, 3, 3},
    '{SSRAM_PAT_BYTE, 16'h0000, 2, 1},
    '{2'h3, 16'h0040, 2, 1},
    '{SSRAM_PAT_SEQ, 16'h0000, 0, 2}};
  always #50 clk = ~clk;
  always @(posedge clk) begin
    tog     <= ~tog;
    drv_cnt <= drv_cnt + ((d0_oe_n && d1_oe_n) ? 0 : 1);
  end
  // a released line toggles so a stale value never passes
  assign l0 = !d0_oe_n ? d0_o : (h0_en ? h0 : tog);
  assign l1 = !d1_oe_n ? d1_o : (h1_en ? h1 : ~tog);
  ssram_spi_slave DUT (.ref_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .sck_i(sck),
    .dual_line_zero_i(l0), .dual_line_zero_o(d0_o), .dual_line_zero_oe_n_o(d0_oe_n),
    .dual_line_one_i(l1), .dual_line_one_o(d1_o), .dual_line_one_oe_n_o(d1_oe_n),
    .dual_serial_operation_o(dual), .access_pattern_config_o(cfg_o));
  ssram_host_model host (.ref_clk_i(clk), .line0_i(l0), .line1_i(l1), .cs_n_o(cs_n), .sck_o(sck),
    .line0_o(h0), .line1_o(h1), .line0_en_o(h0_en), .line1_en_o(h1_en));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] nxt(input logic [1:0] p, input logic [15:0] a);
    case (p)
      SSRAM_PAT_PAGE: nxt = {a[15:5], a[4:0] + 5'h01};
      SSRAM_PAT_SEQ:  nxt = a + 16'h0001;
      default:        nxt = a;
    endcase
  endfunction
  task automatic hdr(input logic [7:0] c, input logic [15:0] a);
    logic [7:0] y;
    host.start();
    host.xb(c, 1'b1, y);
    host.xb(a[15:8], 1'b1, y);
    host.xb(a[7:0], 1'b1, y);
  endtask
  task automatic wr(input logic [1:0] p, input logic [15:0] a, input int n, input logic [7:0] d);
    logic [7:0] y;
    hdr(SSRAM_CMD_WRITE, a);
    for (int k = 0; k < n; k++) begin
      host.xb(d + 8'(k), 1'b1, y);
      if (p != SSRAM_PAT_BYTE || k == 0) mem[a] = d + 8'(k);
      a = nxt(p, a);
    end
    host.stop();
  endtask
  task automatic rd(input logic [1:0] p, input logic [15:0] a, input int n);
    logic [7:0] y;
    hdr(SSRAM_CMD_READ, a);
    for (int k = 0; k < n; k++) begin
      host.xb(8'h00, 1'b0, y);
      chk(y, mem[a]);
      a = nxt(p, a);
    end
    host.stop();
  endtask
  task automatic cfg_set(input logic [7:0] v);
    logic [7:0] y;
    host.start();
    host.xb(SSRAM_CONFIG_WRITE, 1'b1, y);
    host.xb(v, 1'b1, y);
    host.stop();
    chk(cfg_o, {v[7:6], 6'h00});
    host.start();
    host.xb(SSRAM_CONFIG_READ, 1'b1, y);
    host.xb(8'h00, 1'b0, y);
    host.stop();
    chk(y, {v[7:6], 6'h00});
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[r]) begin
      cfg_set({rows[r].pat, 6'h00});
      wr(rows[r].pat, rows[r].adr, rows[r].nw, 8'(r * 16 + 3));
      rd(rows[r].pat, rows[r].adr, rows[r].nr);
      $display("done: row %0d", r);
    end
    cfg_set(8'h3F);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(cfg_o, SSRAM_CFG_RESET);
    chk({dual, d0_oe_n, d1_oe_n}, 3'b011);
    $display("done: reset");
    base = drv_cnt;
    // clocks while select is still high
    host.xb(SSRAM_CONFIG_READ, 1'b1, x);
    hdr(8'h77, 16'hFFFF);
    host.xb(8'h00, 1'b0, x);
    host.stop();
    chk(drv_cnt - base, 0);
    $display("done: ignored");
    wr(SSRAM_PAT_SEQ, 16'h0200, 2, 8'hA0);
    hdr(SSRAM_CMD_WRITE, 16'h0200);
    host.xb(8'h5C, 1'b1, x);
    host.cut_bits = 4;
    host.xb(8'hFF, 1'b1, x);
    host.cut_bits = 0;
    host.stop();
    mem[16'h0200] = 8'h5C;
    rd(SSRAM_PAT_SEQ, 16'h0200, 2);
    $display("done: abort");
    hdr(SSRAM_ENTER_DUAL_CMD, 16'h0000);
    host.stop();
    host.dual_mode = 1'b1;
    chk(dual, 1'b1);
    wr(SSRAM_PAT_SEQ, 16'h0300, 2, 8'hC4);
    rd(SSRAM_PAT_SEQ, 16'h0300, 2);
    cfg_set(8'h80);
    // leave command goes out two bits per clock
    hdr(SSRAM_LEAVE_DUAL_CMD, 16'hFFFF);
    host.stop();
    host.dual_mode = 1'b0;
    chk(dual, 1'b0);
    rd(SSRAM_PAT_PAGE, 16'h0300, 2);
    $display("done: dual");
    tally_and_finish();
  end
endmodule

// ### verilog/ssram_pkg.sv
package ssram_pkg;

  // command codes
  localparam logic [7:0] SSRAM_CMD_READ       = 8'h03;
  localparam logic [7:0] SSRAM_CMD_WRITE      = 8'h02;
  localparam logic [7:0] SSRAM_ENTER_DUAL_CMD = 8'h3B;
  localparam logic [7:0] SSRAM_LEAVE_DUAL_CMD = 8'hFF;
  localparam logic [7:0] SSRAM_CONFIG_READ    = 8'h05;
  localparam logic [7:0] SSRAM_CONFIG_WRITE   = 8'h01;

  // access pattern field, bits 7:6 of access_pattern_config
  localparam int         SSRAM_MODE_HI        = 7;
  localparam int         SSRAM_MODE_LO        = 6;
  localparam logic [1:0] SSRAM_PAT_BYTE       = 2'h0;
  localparam logic [1:0] SSRAM_PAT_PAGE       = 2'h2;
  localparam logic [1:0] SSRAM_PAT_SEQ        = 2'h1;
  localparam logic [7:0] SSRAM_CFG_RESET      = 8'h40;

  // frame geometry
  localparam logic [4:0] SSRAM_CMD_BITS       = 5'h08;
  localparam logic [4:0] SSRAM_ADDR_BITS      = 5'h10;
  localparam logic [4:0] SSRAM_DATA_BITS      = 5'h08;
  localparam int         SSRAM_AW             = 16;
  localparam int         SSRAM_PAGE_AW        = 5;
  localparam int         SSRAM_DEPTH          = 65536;

  // reset values of the pin side
  localparam logic       SSRAM_CS_IDLE        = 1'b1;
  localparam logic       SSRAM_OE_N_OFF       = 1'b1;

  typedef enum logic [6:0] {
    SSRAM_ST_IDLE   = 7'h01,
    SSRAM_ST_CMD    = 7'h02,
    SSRAM_ST_ADDR   = 7'h04,
    SSRAM_ST_RDATA  = 7'h08,
    SSRAM_ST_WDATA  = 7'h10,
    SSRAM_ST_CFGRD  = 7'h20,
    SSRAM_ST_CFGWR  = 7'h40
  } ssram_state_t;

endpackage

// ### verilog/ssram_spi_slave.sv
`timescale 1ns/1ps

// Behaviour
// - first eight input bits after select falls form the instruction byte
// - instruction, address and write data sampled on serial clock rising edges
// - read data changes only after serial clock falling edges
// - all bytes move most significant bit first
// - config bits 7:6 pick byte 00, page 10, sequential 01 (default); 11 reserved
// - byte access: instruction, 16-bit address, then exactly one data byte
// - page access: address wraps inside its 32-byte page
// - sequential access: address increments across pages, FFFFh rolls to 0000h
// - read 0x03 plus address streams data until select rises
// - write 0x02 plus address then data bytes, ended by select rising
// - instruction 0x3B enters dual-line operation
// - instruction 0xFF leaves dual-line operation
// - instruction 0x05 shifts out config register, allowed any time
// - instruction 0x01 loads next eight bits into config register
// - config bits 5:0 read as zero, host writes zero
// - after reset nothing accepted before select is seen low; a select held low through reset counts as a high-to-low edge
// - select high means standby with serial output released
// - dual lines share the serial input and output pins
// - dual-line operation moves two bits per clock, msb first
module ssram_spi_slave
  import ssram_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // serial link pins
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic dual_line_zero_i,
  output logic      dual_line_zero_o,
  output logic      dual_line_zero_oe_n_o,
  input  wire logic dual_line_one_i,
  output logic      dual_line_one_o,
  output logic      dual_line_one_oe_n_o,
  // status
  output logic      dual_serial_operation_o,
  output logic [7:0] access_pattern_config_o
);

  // synchronisers for pins outside the clock domain
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_prev_ff;
  logic sck_s1_ff;
  logic sck_s2_ff;
  logic sck_prev_ff;
  logic d0_s1_ff;
  logic d0_s2_ff;
  logic d1_s1_ff;
  logic d1_s2_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_s1_ff    <= SSRAM_CS_IDLE;
      cs_s2_ff    <= SSRAM_CS_IDLE;
      cs_prev_ff  <= SSRAM_CS_IDLE;
      sck_s1_ff   <= 1'b0;
      sck_s2_ff   <= 1'b0;
      sck_prev_ff <= 1'b0;
      d0_s1_ff    <= 1'b0;
      d0_s2_ff    <= 1'b0;
      d1_s1_ff    <= 1'b0;
      d1_s2_ff    <= 1'b0;
    end else begin
      cs_s1_ff    <= cs_n_i;
      cs_s2_ff    <= cs_s1_ff;
      cs_prev_ff  <= cs_s2_ff;
      sck_s1_ff   <= sck_i;
      sck_s2_ff   <= sck_s1_ff;
      sck_prev_ff <= sck_s2_ff;
      d0_s1_ff    <= dual_line_zero_i;
      d0_s2_ff    <= d0_s1_ff;
      d1_s1_ff    <= dual_line_one_i;
      d1_s2_ff    <= d1_s1_ff;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;

  // edges are judged past the synchroniser, so each shows about three clocks late
  assign sck_rise = sck_s2_ff & ~sck_prev_ff;
  assign sck_fall = ~sck_s2_ff & sck_prev_ff;
  // reset value high means a host holding select low at reset is seen as a falling edge
  assign cs_fall  = cs_prev_ff & ~cs_s2_ff;

  // next address for the selected access pattern
  function automatic logic [SSRAM_AW-1:0] next_addr(input logic [SSRAM_AW-1:0] a,
                                                    input logic [1:0]          pat);
    logic [SSRAM_PAGE_AW-1:0] low;
    low = a[SSRAM_PAGE_AW-1:0] + 1'b1;
    case (pat)
      SSRAM_PAT_PAGE: next_addr = {a[SSRAM_AW-1:SSRAM_PAGE_AW], low};
      SSRAM_PAT_SEQ:  next_addr = a + 1'b1;
      default:        next_addr = a;
    endcase
  endfunction

  // shift one or two input bits in at the lsb end
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic dual,
                                          input logic b1, input logic b0);
    shift_in = dual ? {s[5:0], b1, b0} : {s[6:0], b0};
  endfunction

  // move the next one or two output bits up to the msb end
  function automatic logic [7:0] shift_out(input logic [7:0] s, input logic dual);
    shift_out = dual ? {s[5:0], 2'h0} : {s[6:0], 1'b0};
  endfunction

  // storage; no reset, so contents are undefined until written
  logic [7:0]          mem [0:SSRAM_DEPTH-1];
  logic                mem_we;
  logic [SSRAM_AW-1:0] mem_wa;
  logic [7:0]          mem_wd;

  always_ff @(posedge ref_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // frame state
  ssram_state_t        state_ff, nxt_state;
  logic [4:0]          cnt_ff, nxt_cnt;
  logic [7:0]          sh_ff, nxt_sh;
  logic [7:0]          instr_ff, nxt_instr;
  logic [SSRAM_AW-1:0] addr_ff, nxt_addr;
  logic                is_read_ff, nxt_is_read;
  logic                done_ff, nxt_done;
  logic                dual_ff, nxt_dual;
  logic [7:0]          cfg_ff, nxt_cfg;
  logic                out0_ff, nxt_out0;
  logic                out1_ff, nxt_out1;
  logic                oe0_n_ff, nxt_oe0_n;
  logic                oe1_n_ff, nxt_oe1_n;

  logic [1:0] pattern;
  logic [4:0] step;

  assign pattern = cfg_ff[SSRAM_MODE_HI:SSRAM_MODE_LO];
  // dual mode moves two bits per clock, so every count advances by two
  assign step    = dual_ff ? 5'h02 : 5'h01;

  always_comb begin
    logic [7:0] shn;
    logic [7:0] src;
    logic [4:0] cntn;
    shn         = shift_in(sh_ff, dual_ff, d1_s2_ff, d0_s2_ff);
    src         = 8'h00;
    cntn        = cnt_ff + step;
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_sh      = sh_ff;
    nxt_instr   = instr_ff;
    nxt_addr    = addr_ff;
    nxt_is_read = is_read_ff;
    nxt_done    = done_ff;
    nxt_dual    = dual_ff;
    nxt_cfg     = cfg_ff;
    nxt_out0    = out0_ff;
    nxt_out1    = out1_ff;
    nxt_oe0_n   = oe0_n_ff;
    nxt_oe1_n   = oe1_n_ff;
    mem_we      = 1'b0;
    mem_wa      = addr_ff;
    mem_wd      = shn;
    if (cs_s2_ff) begin
      // deselect drops any partial byte and restarts the counters
      nxt_state = SSRAM_ST_IDLE;
      nxt_cnt   = 5'h00;
      nxt_done  = 1'b0;
      nxt_oe0_n = SSRAM_OE_N_OFF;
      nxt_oe1_n = SSRAM_OE_N_OFF;
    end else begin
      case (state_ff)
        SSRAM_ST_IDLE: begin
          if (cs_fall) begin
            nxt_state = SSRAM_ST_CMD;
            nxt_cnt   = 5'h00;
          end
        end
        SSRAM_ST_CMD: begin
          if (sck_rise) begin
            nxt_sh  = shn;
            nxt_cnt = cntn;
            if (cntn == SSRAM_CMD_BITS) begin
              nxt_instr = shn;
              nxt_cnt   = 5'h00;
              nxt_done  = 1'b0;
              case (shn)
                SSRAM_CMD_READ: begin
                  nxt_state   = SSRAM_ST_ADDR;
                  nxt_is_read = 1'b1;
                end
                SSRAM_CMD_WRITE: begin
                  nxt_state   = SSRAM_ST_ADDR;
                  nxt_is_read = 1'b0;
                end
                SSRAM_CONFIG_READ: nxt_state = SSRAM_ST_CFGRD;
                SSRAM_CONFIG_WRITE: nxt_state = SSRAM_ST_CFGWR;
                // width changes park in idle, so trailing bits are ignored
                SSRAM_ENTER_DUAL_CMD: begin
                  nxt_dual  = 1'b1;
                  nxt_state = SSRAM_ST_IDLE;
                end
                SSRAM_LEAVE_DUAL_CMD: begin
                  // accepted in whichever width is active
                  nxt_dual  = 1'b0;
                  nxt_state = SSRAM_ST_IDLE;
                end
                default: nxt_state = SSRAM_ST_IDLE;
              endcase
            end
          end
        end
        SSRAM_ST_ADDR: begin
          if (sck_rise) begin
            nxt_addr = dual_ff ? {addr_ff[SSRAM_AW-3:0], d1_s2_ff, d0_s2_ff}
                               : {addr_ff[SSRAM_AW-2:0], d0_s2_ff};
            nxt_cnt  = cntn;
            if (cntn == SSRAM_ADDR_BITS) begin
              nxt_cnt   = 5'h00;
              nxt_state = is_read_ff ? SSRAM_ST_RDATA : SSRAM_ST_WDATA;
            end
          end
        end
        SSRAM_ST_RDATA, SSRAM_ST_CFGRD: begin
          if (sck_fall) begin
            // next byte is fetched on the fall after bit 0, so a stream has no gap
            if (cnt_ff == 5'h00) begin
              // one byte per frame in byte access and for the config read
              if (done_ff && (state_ff == SSRAM_ST_CFGRD || pattern == SSRAM_PAT_BYTE)) begin
                nxt_state = SSRAM_ST_IDLE;
                nxt_oe0_n = SSRAM_OE_N_OFF;
                nxt_oe1_n = SSRAM_OE_N_OFF;
              end else begin
                if (state_ff == SSRAM_ST_CFGRD) begin
                  src = cfg_ff;
                end else begin
                  src      = mem[addr_ff];
                  nxt_addr = next_addr(addr_ff, pattern);
                end
                nxt_done  = 1'b1;
                nxt_out1  = src[7];
                nxt_out0  = src[6];
                nxt_oe1_n = 1'b0;
                nxt_oe0_n = ~dual_ff;
                nxt_sh    = shift_out(src, dual_ff);
                nxt_cnt   = SSRAM_DATA_BITS - step;
              end
            end else begin
              nxt_out1 = sh_ff[7];
              nxt_out0 = sh_ff[6];
              nxt_sh   = shift_out(sh_ff, dual_ff);
              nxt_cnt  = cnt_ff - step;
            end
          end
        end
        SSRAM_ST_WDATA: begin
          if (sck_rise) begin
            nxt_sh  = shn;
            nxt_cnt = cntn;
            // a byte cut short by select never reaches this store
            if (cntn == SSRAM_DATA_BITS) begin
              mem_we   = 1'b1;
              nxt_cnt  = 5'h00;
              nxt_addr = next_addr(addr_ff, pattern);
              if (pattern == SSRAM_PAT_BYTE) begin
                nxt_state = SSRAM_ST_IDLE;
              end
            end
          end
        end
        SSRAM_ST_CFGWR: begin
          if (sck_rise) begin
            nxt_sh  = shn;
            nxt_cnt = cntn;
            if (cntn == SSRAM_DATA_BITS) begin
              // reserved bits are never stored so they always read zero
              nxt_cfg   = {shn[SSRAM_MODE_HI:SSRAM_MODE_LO], 6'h00};
              nxt_state = SSRAM_ST_IDLE;
            end
          end
        end
        default: begin
          nxt_state = SSRAM_ST_IDLE;
          nxt_oe0_n = SSRAM_OE_N_OFF;
          nxt_oe1_n = SSRAM_OE_N_OFF;
        end
      endcase
    end
  end

  // idle inside a frame also means "ignore until select rises"
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff   <= SSRAM_ST_IDLE;
      cnt_ff     <= 5'h00;
      sh_ff      <= 8'h00;
      instr_ff   <= 8'h00;
      addr_ff    <= 16'h0000;
      is_read_ff <= 1'b0;
      done_ff    <= 1'b0;
      dual_ff    <= 1'b0;
      cfg_ff     <= SSRAM_CFG_RESET;
      out0_ff    <= 1'b0;
      out1_ff    <= 1'b0;
      oe0_n_ff   <= SSRAM_OE_N_OFF;
      oe1_n_ff   <= SSRAM_OE_N_OFF;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      sh_ff      <= nxt_sh;
      instr_ff   <= nxt_instr;
      addr_ff    <= nxt_addr;
      is_read_ff <= nxt_is_read;
      done_ff    <= nxt_done;
      dual_ff    <= nxt_dual;
      cfg_ff     <= nxt_cfg;
      out0_ff    <= nxt_out0;
      out1_ff    <= nxt_out1;
      oe0_n_ff   <= nxt_oe0_n;
      oe1_n_ff   <= nxt_oe1_n;
    end
  end

  // every pin output is a register, so no decode glitch reaches the pads
  assign dual_line_zero_o        = out0_ff;
  assign dual_line_zero_oe_n_o   = oe0_n_ff;
  assign dual_line_one_o         = out1_ff;
  assign dual_line_one_oe_n_o    = oe1_n_ff;
  assign dual_serial_operation_o = dual_ff;
  assign access_pattern_config_o = cfg_ff;

endmodule
